// file: hdl/slaa_pkg.sv
// package: register map, field positions and constants of the line abort assist unit
package slaa_pkg;
  // ----------------------------------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ctrl_off      = 8'h00; // start control
  localparam logic [7:0] detect_off    = 8'h04; // detect indication
  localparam logic [7:0] tx_state_off  = 8'h08; // tx dma chan state word
  localparam logic [7:0] rx_state_off  = 8'h0c; // rx dma chan state word
  localparam logic [7:0] tx_irq_off    = 8'h10;
  localparam logic [7:0] tx_jump_off   = 8'h14;
  localparam logic [7:0] tx_stall_off  = 8'h18;
  localparam logic [7:0] rx_irq_off    = 8'h1c;
  localparam logic [7:0] rx_jump_off   = 8'h20;
  localparam logic [7:0] rx_stall_off  = 8'h24;
  localparam logic [7:0] cond_off      = 8'h28; // condition outputs, read only
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int ext_wait_pos     = 0; // external wait bit
  localparam int abort_detect_pos = 5; // abort detect status bit
  localparam int start_pos        = 0;
  localparam int detect_pos       = 0;
  // ----------------------------------------------------------------
  // masks, reset values and counts
  // ----------------------------------------------------------------
  localparam logic [7:0] tx_impl_mask = 8'h21; // bits 5 and 0
  localparam logic [7:0] rx_impl_mask = 8'h01; // bit 0
  localparam logic [7:0] sel_reset    = 8'h00;
  localparam int         abort_ones   = 16;    // run length of ones
  // ----------------------------------------------------------------
  // monitor states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    mon_idle   = 2'b00,
    mon_watch  = 2'b01,
    mon_hold   = 2'b11
  } slaa_mon_type;
endpackage

// file: hdl/slaa_sync.sv
// three stage synchroniser for pins from outside the clock domain
`timescale 1ns/1ns
module slaa_sync #(
  parameter int width = 1
) (
  // clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // pin side
  input  wire logic [width-1:0] pin_in,
  // synchronised level, changes once stages two and three agree
  output logic      [width-1:0] level_out
);
  logic [width-1:0] s1_reg, s2_reg, s3_reg, lvl_reg;
  logic [width-1:0] lvl_next;

  // per bit: take new value only where stages two and three agree
  always_comb begin
    for (int i = 0; i < width; i++) begin
      lvl_next[i] = (s2_reg[i] == s3_reg[i]) ? s3_reg[i] : lvl_reg[i];
    end
  end

  // shift chain, first stage feeds only the second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_reg  <= '0;
      s2_reg  <= '0;
      s3_reg  <= '0;
      lvl_reg <= '0;
    end else begin
      s1_reg  <= pin_in;
      s2_reg  <= s1_reg;
      s3_reg  <= s2_reg;
      lvl_reg <= lvl_next;
    end
  end

  assign level_out = lvl_reg;
endmodule

// file: hdl/slaa_top.sv
// line abort assist unit with dma status bits and condition selects
//
// Register access over APB and the register addresses were left to the implementer.
`timescale 1ns/1ns
module slaa_top #(
  parameter int ones_count = slaa_pkg::abort_ones
) (
  // apb clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // serial line side (pins)
  input  wire logic        ctrl_rts_n,
  input  wire logic        transmit_serial_line,
  output logic             line_rts_n,
  // external wait inputs (pins)
  input  wire logic        tx_ext_wait,
  input  wire logic        rx_ext_wait,
  // dma condition outputs
  output logic             tx_irq_cond,
  output logic             tx_jump_cond,
  output logic             tx_stall_cond,
  output logic             rx_irq_cond,
  output logic             rx_jump_cond,
  output logic             rx_stall_cond
);
  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  // request pin enters inverted: the chain resets to zero, and the inversion makes that
  // read as an idle (high) request, so no false assert reaches the line after reset
  logic [3:0] pins_s;
  slaa_sync #(.width(4)) u_sync (
    .pclk      (pclk),
    .presetn   (presetn),
    .pin_in    ({rx_ext_wait, tx_ext_wait, transmit_serial_line, !ctrl_rts_n}),
    .level_out (pins_s)
  );
  wire logic rts_s  = !pins_s[0];
  wire logic txd_s  = pins_s[1];
  wire logic txw_s  = pins_s[2];
  wire logic rxw_s  = pins_s[3];

  // ----------------------------------------------------------------
  // helper functions
  // ----------------------------------------------------------------
  // any selected, implemented status bit set
  function automatic logic cond_hit(input logic [7:0] st, input logic [7:0] sel);
    cond_hit = |(st & sel);
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  localparam int cw = $clog2(ones_count + 1);
  slaa_pkg::slaa_mon_type mon_reg, mon_next;
  logic          start_reg, start_next;
  logic          detect_reg, detect_next;
  logic [cw-1:0] ones_reg, ones_next;
  logic          rts_reg, rts_next;
  logic [7:0]    txi_reg, txi_next, txj_reg, txj_next, txs_reg, txs_next;
  logic [7:0]    rxi_reg, rxi_next, rxj_reg, rxj_next, rxs_reg, rxs_next;
  logic [31:0]   rd_reg, rd_next;
  logic          rdy_reg, rdy_next, err_reg, err_next;
  logic [5:0]    cond_reg, cond_next;
  logic [7:0]    tx_state, rx_state;

  // status words, unimplemented bits read zero
  always_comb begin
    tx_state = 8'h00;
    tx_state[slaa_pkg::abort_detect_pos] = detect_reg;
    tx_state[slaa_pkg::ext_wait_pos]     = txw_s;
    rx_state = 8'h00;
    rx_state[slaa_pkg::ext_wait_pos]     = rxw_s;
  end

  wire logic setup  = psel && !penable;
  wire logic wr_acc = psel && penable && pwrite && rdy_reg;

  // ----------------------------------------------------------------
  // register file and apb next state
  // ----------------------------------------------------------------
  always_comb begin
    start_next = start_reg;
    txi_next = txi_reg;
    txj_next = txj_reg;
    txs_next = txs_reg;
    rxi_next = rxi_reg;
    rxj_next = rxj_reg;
    rxs_next = rxs_reg;
    rd_next  = rd_reg;
    err_next = 1'b0;
    rdy_next = setup; // one wait-free access cycle after setup
    if (wr_acc) begin
      case (paddr)
        slaa_pkg::ctrl_off:     start_next = pwdata[slaa_pkg::start_pos];
        slaa_pkg::tx_irq_off:   txi_next = pwdata[7:0] & slaa_pkg::tx_impl_mask;
        slaa_pkg::tx_jump_off:  txj_next = pwdata[7:0] & slaa_pkg::tx_impl_mask;
        slaa_pkg::tx_stall_off: txs_next = pwdata[7:0] & slaa_pkg::tx_impl_mask;
        slaa_pkg::rx_irq_off:   rxi_next = pwdata[7:0] & slaa_pkg::rx_impl_mask;
        slaa_pkg::rx_jump_off:  rxj_next = pwdata[7:0] & slaa_pkg::rx_impl_mask;
        slaa_pkg::rx_stall_off: rxs_next = pwdata[7:0] & slaa_pkg::rx_impl_mask;
        default: ;
      endcase
    end
    if (setup) begin
      err_next = 1'b0;
      case (paddr)
        slaa_pkg::ctrl_off:     rd_next = {31'h0, start_reg};
        slaa_pkg::detect_off:   rd_next = {31'h0, detect_reg};
        slaa_pkg::tx_state_off: rd_next = {24'h0, tx_state};
        slaa_pkg::rx_state_off: rd_next = {24'h0, rx_state};
        slaa_pkg::tx_irq_off:   rd_next = {24'h0, txi_reg};
        slaa_pkg::tx_jump_off:  rd_next = {24'h0, txj_reg};
        slaa_pkg::tx_stall_off: rd_next = {24'h0, txs_reg};
        slaa_pkg::rx_irq_off:   rd_next = {24'h0, rxi_reg};
        slaa_pkg::rx_jump_off:  rd_next = {24'h0, rxj_reg};
        slaa_pkg::rx_stall_off: rd_next = {24'h0, rxs_reg};
        slaa_pkg::cond_off:     rd_next = {26'h0, cond_reg};
        default: begin
          rd_next  = 32'h0;
          err_next = 1'b1; // unmapped address
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // abort run monitor
  // ----------------------------------------------------------------
  always_comb begin
    mon_next    = mon_reg;
    ones_next   = ones_reg;
    detect_next = detect_reg;
    rts_next    = rts_s; // pass through by default
    case (mon_reg)
      slaa_pkg::mon_idle: begin
        ones_next   = '0;
        detect_next = 1'b0;
        if (start_reg) begin
          mon_next = slaa_pkg::mon_watch;
        end
      end
      slaa_pkg::mon_watch: begin
        if (!txd_s) begin
          ones_next = '0;
        end else if (ones_reg == cw'(ones_count - 1)) begin
          mon_next    = slaa_pkg::mon_hold;
          detect_next = 1'b1;
          rts_next    = 1'b1;
        end else begin
          ones_next = ones_reg + cw'(1);
        end
      end
      slaa_pkg::mon_hold: begin
        rts_next = 1'b1; // line forced high, ends the run
      end
      default: mon_next = slaa_pkg::mon_idle;
    endcase
    if (!start_next) begin
      mon_next = slaa_pkg::mon_idle;
      if (mon_reg != slaa_pkg::mon_idle) begin
        rts_next = rts_s;
      end
    end
  end

  // condition outputs from selected status bits
  always_comb begin
    cond_next[0] = cond_hit(tx_state, txi_reg);
    cond_next[1] = cond_hit(tx_state, txj_reg);
    cond_next[2] = cond_hit(tx_state, txs_reg);
    cond_next[3] = cond_hit(rx_state, rxi_reg);
    cond_next[4] = cond_hit(rx_state, rxj_reg);
    cond_next[5] = cond_hit(rx_state, rxs_reg);
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mon_reg    <= slaa_pkg::mon_idle;
      start_reg  <= 1'b0;
      detect_reg <= 1'b0;
      ones_reg   <= '0;
      rts_reg    <= 1'b1;
      txi_reg    <= slaa_pkg::sel_reset;
      txj_reg    <= slaa_pkg::sel_reset;
      txs_reg    <= slaa_pkg::sel_reset;
      rxi_reg    <= slaa_pkg::sel_reset;
      rxj_reg    <= slaa_pkg::sel_reset;
      rxs_reg    <= slaa_pkg::sel_reset;
      rd_reg     <= 32'h0;
      rdy_reg    <= 1'b0;
      err_reg    <= 1'b0;
      cond_reg   <= 6'h00;
    end else begin
      mon_reg    <= mon_next;
      start_reg  <= start_next;
      detect_reg <= detect_next;
      ones_reg   <= ones_next;
      rts_reg    <= rts_next;
      txi_reg    <= txi_next;
      txj_reg    <= txj_next;
      txs_reg    <= txs_next;
      rxi_reg    <= rxi_next;
      rxj_reg    <= rxj_next;
      rxs_reg    <= rxs_next;
      rd_reg     <= rd_next;
      rdy_reg    <= rdy_next;
      err_reg    <= err_next;
      cond_reg   <= cond_next;
    end
  end

  // outputs straight from flip-flops
  assign prdata        = rd_reg;
  assign pready        = rdy_reg;
  assign pslverr       = err_reg; // only set in the access cycle
  assign line_rts_n    = rts_reg;
  assign tx_irq_cond   = cond_reg[0];
  assign tx_jump_cond  = cond_reg[1];
  assign tx_stall_cond = cond_reg[2];
  assign rx_irq_cond   = cond_reg[3];
  assign rx_jump_cond  = cond_reg[4];
  assign rx_stall_cond = cond_reg[5];

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_pass_through: assert property (@(posedge pclk) disable iff (!presetn)
    (!start_reg && !$past(start_reg)) |=> line_rts_n == $past(rts_s))
    else $error("line request not passed through");
  a_watch_pass: assert property (@(posedge pclk) disable iff (!presetn)
    (mon_reg == slaa_pkg::mon_watch && start_next && ones_reg != cw'(ones_count - 1))
      |=> line_rts_n == $past(rts_s))
    else $error("request not passed while watching");
  a_run_detect: assert property (@(posedge pclk) disable iff (!presetn)
    (mon_reg == slaa_pkg::mon_watch && txd_s && start_next && ones_reg == cw'(ones_count - 1))
      |=> detect_reg && line_rts_n)
    else $error("abort run not detected");
  a_hold_high: assert property (@(posedge pclk) disable iff (!presetn)
    (mon_reg == slaa_pkg::mon_hold && start_reg) |-> line_rts_n)
    else $error("line not held high after run");
  a_tx_status: assert property (@(posedge pclk) disable iff (!presetn)
    (tx_state & ~slaa_pkg::tx_impl_mask) == 8'h00)
    else $error("unimplemented tx status bit set");
  a_rx_status: assert property (@(posedge pclk) disable iff (!presetn)
    rx_state[7:1] == 7'h00)
    else $error("unimplemented rx status bit set");
  a_tx_select: assert property (@(posedge pclk) disable iff (!presetn)
    ((txi_reg | txj_reg | txs_reg) & ~slaa_pkg::tx_impl_mask) == 8'h00)
    else $error("tx select holds unimplemented bit");
  a_rx_select: assert property (@(posedge pclk) disable iff (!presetn)
    ((rxi_reg | rxj_reg | rxs_reg) & ~slaa_pkg::rx_impl_mask) == 8'h00)
    else $error("rx select holds unimplemented bit");
  a_idle_clear: assert property (@(posedge pclk) disable iff (!presetn)
    (mon_reg == slaa_pkg::mon_idle) |=> !detect_reg)
    else $error("detect left set while idle");
endmodule

// file: verification/slaa_far_model.sv
// far side model: serial controller request pin and transmit data line
`timescale 1ns/1ns
module slaa_far_model (
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // commands from host software
  input  wire logic       rts_on,
  input  wire logic [1:0] line_mode,
  // pins toward the assist unit
  output logic            ctrl_rts_n,
  output logic            transmit_serial_line
);
  localparam logic [7:0] flag_pat = 8'h7e; // idle flag, at most six ones in a row
  logic [2:0] bit_idx_reg;

  // ----------------------------------------------------------------
  // bit position inside the idle flag pattern
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bit_idx_reg <= 3'h0;
    end else begin
      bit_idx_reg <= bit_idx_reg + 3'h1;
    end
  end

  // request pin is active low, set by software
  assign ctrl_rts_n = !rts_on;

  // mode 0 flag idle, 1 mark idle, 2 space
  always_comb begin
    case (line_mode)
      2'h0:    transmit_serial_line = flag_pat[bit_idx_reg];
      2'h1:    transmit_serial_line = 1'b1;
      default: transmit_serial_line = 1'b0;
    endcase
  end
endmodule

// file: verification/test_serial_tx_abort_assist.sv
// testbench of the line abort assist unit
`timescale 1ns/1ns
module test_serial_tx_abort_assist;
  localparam int run_len = slaa_pkg::abort_ones;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        line_rts_n, ctrl_rts_n, txd, rts_on, tx_wait, rx_wait;
  logic [1:0]  line_mode;
  wire  [2:0]  tx_c, rx_c;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic        rerr;
  int          err_count, compares, cycles;

  // ----------------------------------------------------------------
  // design, far side and clock
  // ----------------------------------------------------------------
  slaa_top #(.ones_count(run_len)) slaa_top_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ctrl_rts_n(ctrl_rts_n), .transmit_serial_line(txd), .line_rts_n(line_rts_n),
    .tx_ext_wait(tx_wait), .rx_ext_wait(rx_wait),
    .tx_irq_cond(tx_c[0]), .tx_jump_cond(tx_c[1]), .tx_stall_cond(tx_c[2]),
    .rx_irq_cond(rx_c[0]), .rx_jump_cond(rx_c[1]), .rx_stall_cond(rx_c[2]));
  slaa_far_model slaa_far_model_i (
    .pclk(pclk), .presetn(presetn), .rts_on(rts_on), .line_mode(line_mode),
    .ctrl_rts_n(ctrl_rts_n), .transmit_serial_line(txd));

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  // hang guard
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 5000) begin
      err_count++;
      final_report();
    end
  end

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rdat, exp);
    chk(rerr, 1'b0);
  endtask

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    @(posedge pclk);
    chk(line_rts_n, 1'b1);
    rd(slaa_pkg::ctrl_off, 32'h0);
    rd(slaa_pkg::detect_off, 32'h0);
    chk(line_rts_n, 1'b1);
  endtask

  task automatic t_pass();
    for (int v = 1; v >= 0; v--) begin
      rts_on <= v[0];
      repeat (8) @(posedge pclk);
      chk(line_rts_n, !v[0]);
    end
  endtask

  task automatic t_select();
    tx_wait <= 1'b1;
    rx_wait <= 1'b1;
    repeat (6) @(posedge pclk);
    rd(slaa_pkg::tx_state_off, 32'h01);
    rd(slaa_pkg::rx_state_off, 32'h01);
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, slaa_pkg::tx_irq_off + 8'(4 * i), 32'hff);
      rd(slaa_pkg::tx_irq_off + 8'(4 * i), 32'h21);
      apb(1'b1, slaa_pkg::rx_irq_off + 8'(4 * i), 32'hff);
      rd(slaa_pkg::rx_irq_off + 8'(4 * i), 32'h01);
    end
    apb(1'b1, slaa_pkg::tx_state_off, 32'hff);
    rd(slaa_pkg::tx_state_off, 32'h01);
    chk({tx_c, rx_c}, 6'h3f);
    tx_wait <= 1'b0;
    rx_wait <= 1'b0;
    repeat (8) @(posedge pclk);
    chk({tx_c, rx_c}, 6'h00);
    rd(slaa_pkg::cond_off, 32'h0);
    apb(1'b0, 8'h2c, 32'h0);
    chk(rdat, 32'h0);
    chk(rerr, 1'b1);
  endtask

  task automatic t_abort();
    line_mode <= 2'h0;
    rts_on <= 1'b1;
    repeat (4) @(posedge pclk);
    rts_on <= 1'b0;
    repeat (2) @(posedge pclk);
    rts_on <= 1'b1;
    apb(1'b1, slaa_pkg::ctrl_off, 32'h1);
    // flag idle never makes a run of run_len ones
    repeat (40) @(posedge pclk);
    rd(slaa_pkg::detect_off, 32'h0);
    chk(line_rts_n, 1'b0);
    line_mode <= 2'h2;
    repeat (8) @(posedge pclk);
    line_mode <= 2'h1;
    repeat (run_len - 1) @(posedge pclk);
    line_mode <= 2'h2;
    repeat (10) @(posedge pclk);
    rd(slaa_pkg::detect_off, 32'h0);
    chk(line_rts_n, 1'b0);
    line_mode <= 2'h1;
    repeat (run_len + 10) @(posedge pclk);
    rd(slaa_pkg::detect_off, 32'h1);
    chk(line_rts_n, 1'b1);
    chk({tx_c, rx_c}, 6'h38);
    rd(slaa_pkg::tx_state_off, 32'h20);
    rd(slaa_pkg::cond_off, 32'h07);
    rts_on <= 1'b0;
    repeat (8) @(posedge pclk);
    chk(line_rts_n, 1'b1);
    apb(1'b1, slaa_pkg::ctrl_off, 32'h0);
    repeat (3) @(posedge pclk);
    rd(slaa_pkg::detect_off, 32'h0);
    // request again: must reach the line now that the hold is gone
    rts_on <= 1'b1;
    repeat (8) @(posedge pclk);
    chk(line_rts_n, 1'b0);
    rts_on <= 1'b0;
    line_mode <= 2'h0;
    repeat (8) @(posedge pclk);
    chk(line_rts_n, 1'b1);
  endtask

  // reset in mid-run with detect set
  task automatic t_midreset();
    apb(1'b1, slaa_pkg::ctrl_off, 32'h1);
    line_mode <= 2'h1;
    repeat (30) @(posedge pclk);
    rd(slaa_pkg::detect_off, 32'h1);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    line_mode <= 2'h0;
    @(posedge pclk);
    t_reset();
    rd(slaa_pkg::tx_irq_off, 32'h0);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {rts_on, tx_wait, rx_wait, line_mode} = '0;
    err_count = 0;
    compares = 0;
    cycles = 0;
    presetn = 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_pass();
    t_select();
    t_abort();
    t_midreset();
    final_report();
  end
endmodule
